/* design/ulmsc_params.svh */
// Register map, field positions, reset values and timing counts
`ifndef ULMSC_PARAMS_SVH
`define ULMSC_PARAMS_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define UL_AW        6
`define UL_IDX_DATA  4'h0
`define UL_IDX_DIVH  4'h1
`define UL_IDX_DIVF  4'h2
`define UL_IDX_FMT   4'h3
`define UL_IDX_MOC   4'h4
`define UL_IDX_LCS   4'h5
`define UL_IDX_MIS   4'h6
`define UL_IDX_SPR   4'h7
`define UL_IDX_EFR   4'h8
`define UL_IDX_FCTL  4'h9
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UL_FMT_STOP  2
`define UL_FMT_PEN   3
`define UL_FMT_PTYP  4
`define UL_FMT_FORCE 5
`define UL_FMT_BRK   6
`define UL_FMT_DLAB  7
`define UL_MOC_DTR   0
`define UL_MOC_RTS   1
`define UL_MOC_OP1   2
`define UL_MOC_OP2   3
`define UL_MOC_LOOP  4
`define UL_MOC_XANY  5
`define UL_MOC_RSVD  6
`define UL_MOC_PRE   7
`define UL_EFR_ENH   4
`define UL_FCTL_HALT 0
// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define UL_FMT_RST   8'h05
`define UL_SPR_RST   8'hff
`define UL_DIV_RST   16'h0001
`define UL_RESP_OK   2'b00
`define UL_RESP_ERR  2'b10
// ----------------------------------------
// Timing counts in baud ticks and clocks, FIFO depth in entries
// ----------------------------------------
`define UL_OVS       6'd16
`define UL_HALF      6'd8
`define UL_STOP15    6'd24
`define UL_STOP2     6'd32
`define UL_PRE_LAST  2'd3
`define UL_DEPTH     7'd64
`endif

/* design/ulmsc_pkg.sv */
// State types of the serial engines
package ulmsc_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } ulmsc_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRKW  = 3'b101
  } ulmsc_rx_t;
endpackage

/* design/ulmsc_top.sv */
// Summary of operation
// (R1) Parity enable adds and checks parity bit
// (R2) Parity type: 0 odd, 1 even
// (R3) Forced parity: type 0 gives 1, 1 gives 0
// (R4) Break control holds serial output low when loopback off
// (R5) Divisor access selects divisor registers
// (R6) Terminal-ready pin low when bit set and loopback off
// (R7) Request-to-send pin low when bit set and loopback off
// (R8) Loopback ring input follows output-one bit
// (R9) Offset six is threshold only when banked
// (R10) Offset seven is trigger only when banked
// (R11) Output-two drives interrupt, output-two pin low
// (R12) Loopback routes outputs back to inputs
// (R13) Any received character resumes halted transmit
// (R14) Prescaler divides baud clock by four
// (R15) Data ready while receive FIFO nonempty
// (R16) Full FIFO: overrun set, byte dropped
// (R17) Parity error tags head character
// (R18) Framing error tags head character
// (R19) One break character per break event
// (R20) Holding-empty set when empty, cleared on load
// (R21) Idle flag when holding and shifter empty
// (R22) FIFO error while any tagged byte stored
// (R23) Word length five to eight, stop bits
// (R24) Forced parity mismatch reports parity error
`timescale 1ns/1ps
`include "ulmsc_params.svh"
module ulmsc_top
  import ulmsc_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               s_axi_awvalid,
  input  wire logic [`UL_AW-1:0]  s_axi_awaddr,
  output logic                    s_axi_awready,
  input  wire logic               s_axi_wvalid,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_wready,
  output logic                    s_axi_bvalid,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_bready,
  input  wire logic               s_axi_arvalid,
  input  wire logic [`UL_AW-1:0]  s_axi_araddr,
  output logic                    s_axi_arready,
  output logic                    s_axi_rvalid,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  input  wire logic               s_axi_rready,
  input  wire logic               rxd,
  input  wire logic               cts_n,
  input  wire logic               dsr_n,
  input  wire logic               ri_n,
  input  wire logic               cd_n,
  output logic                    txd,
  output logic                    dtr_n,
  output logic                    rts_n,
  output logic                    op2_n,
  output logic                    irq,
  output logic                    irq_oe_n
);
  // ----------------------------------------
  // Parity of the active data bits
  // ----------------------------------------
  function automatic logic par_calc(input logic [7:0] d, input logic [1:0] wl,
                                    input logic pt, input logic fp);
    logic [7:0] m;
    m = d & (8'hff >> (2'd3 - wl));
    par_calc = fp ? ~pt : (pt ? ^m : ~^m);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  fmt_reg, moc_reg, spr_reg, tcr_reg, tlr_reg, efr_reg, fctl_reg;
  logic [7:0]  divf_reg, thr_reg, tx_sh_reg, rx_sh_reg;
  logic [15:0] div_reg, div_cnt_reg;
  logic [1:0]  pre_cnt_reg;
  logic        thr_full_reg, ovr_reg, tx_pbit_reg, rx_pbit_reg, rx_zero_reg;
  logic [3:0]  msr_prev_reg, delta_reg;
  logic [5:0]  tx_tcnt_reg, rx_tcnt_reg, wr_ptr_reg, rd_ptr_reg;
  logic [2:0]  tx_bit_reg, rx_bit_reg;
  logic [6:0]  cnt_reg, err_cnt_reg;
  logic [10:0] mem [0:63];
  ulmsc_tx_t   tx_st_reg;
  ulmsc_rx_t   rx_st_reg;
  logic        aw_have_reg, w_have_reg, w_strb_reg;
  logic [3:0]  aw_idx_reg;
  logic [7:0]  w_data_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire         aw_hs   = s_axi_awvalid & s_axi_awready;
  wire         w_hs    = s_axi_wvalid & s_axi_wready;
  wire         wr_do   = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire         rd_do   = s_axi_arvalid & s_axi_arready;
  wire         aw_nx   = aw_hs | (aw_have_reg & ~wr_do);
  wire         w_nx    = w_hs | (w_have_reg & ~wr_do);
  wire         bv_nx   = wr_do | (s_axi_bvalid & ~s_axi_bready);
  wire         rv_nx   = rd_do | (s_axi_rvalid & ~s_axi_rready);
  wire [3:0]   ar_idx  = s_axi_araddr[5:2];
  wire         dlab    = fmt_reg[`UL_FMT_DLAB];
  wire         enh     = efr_reg[`UL_EFR_ENH];
  wire         bank    = enh & moc_reg[`UL_MOC_OP1];
  wire         loop    = moc_reg[`UL_MOC_LOOP];
  wire         we      = wr_do & w_strb_reg;
  wire         we_data = we & (aw_idx_reg == `UL_IDX_DATA) & ~dlab;
  wire         we_divl = we & (aw_idx_reg == `UL_IDX_DATA) & dlab; // R5
  wire         we_divh = we & (aw_idx_reg == `UL_IDX_DIVH) & dlab; // R5
  wire         we_divf = we & (aw_idx_reg == `UL_IDX_DIVF) & dlab; // R5
  wire         we_fmt  = we & (aw_idx_reg == `UL_IDX_FMT);
  wire         we_moc  = we & (aw_idx_reg == `UL_IDX_MOC);
  wire         we_tcr  = we & (aw_idx_reg == `UL_IDX_MIS) & bank; // R9
  wire         we_spr  = we & (aw_idx_reg == `UL_IDX_SPR) & ~bank; // R10
  wire         we_tlr  = we & (aw_idx_reg == `UL_IDX_SPR) & bank; // R10
  wire         we_efr  = we & (aw_idx_reg == `UL_IDX_EFR);
  wire         we_fctl = we & (aw_idx_reg == `UL_IDX_FCTL);
  wire         rd_pop  = rd_do & (ar_idx == `UL_IDX_DATA) & ~dlab;
  wire         rd_lcs  = rd_do & (ar_idx == `UL_IDX_LCS);
  wire         rd_msr  = rd_do & (ar_idx == `UL_IDX_MIS) & ~bank; // R9
  wire         ar_bad  = ar_idx > `UL_IDX_FCTL;
  // Enhanced-only bits keep their value unless enhanced mode is on
  wire [7:0]   moc_keep = {~enh, 1'b1, ~enh, 5'h00};
  wire [7:0]   moc_wr   = ((w_data_reg & ~moc_keep) | (moc_reg & moc_keep))
                          & ~(8'h01 << `UL_MOC_RSVD); // R13 R14

  // ----------------------------------------
  // Baud tick with prescaler
  // ----------------------------------------
  wire         pre_tick = ~moc_reg[`UL_MOC_PRE] | (pre_cnt_reg == `UL_PRE_LAST); // R14
  wire         tick     = pre_tick & (div_cnt_reg + 16'h0001 >= div_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_reg <= 2'd0;
      div_cnt_reg <= 16'h0000;
    end else if (ce) begin
      pre_cnt_reg <= pre_tick ? 2'd0 : pre_cnt_reg + 2'd1; // R14
      if (pre_tick) div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire [1:0]   wl      = fmt_reg[1:0];
  wire [2:0]   last    = {1'b0, wl} + 3'd4; // R23
  wire         pen     = fmt_reg[`UL_FMT_PEN];
  wire         halt    = fctl_reg[`UL_FCTL_HALT];
  wire [5:0]   stop_len = !fmt_reg[`UL_FMT_STOP] ? `UL_OVS :
                          (wl == 2'd0 ? `UL_STOP15 : `UL_STOP2); // R23
  wire [5:0]   tx_len  = (tx_st_reg == TX_STOP) ? stop_len : `UL_OVS;
  wire         tx_end  = tick & (tx_tcnt_reg == tx_len - 6'd1);
  wire         tx_load = (tx_st_reg == TX_IDLE) & thr_full_reg & ~halt;
  wire         tx_line = (tx_st_reg == TX_START) ? 1'b0 :
                         (tx_st_reg == TX_DATA)  ? tx_sh_reg[0] :
                         (tx_st_reg == TX_PAR)   ? tx_pbit_reg : 1'b1;
  wire         tx_wire = tx_line & ~fmt_reg[`UL_FMT_BRK]; // R4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_reg   <= TX_IDLE;
      tx_tcnt_reg <= 6'd0;
      tx_bit_reg  <= 3'd0;
      tx_sh_reg   <= 8'h00;
      tx_pbit_reg <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        tx_sh_reg   <= thr_reg;
        tx_pbit_reg <= par_calc(thr_reg, wl, fmt_reg[`UL_FMT_PTYP],
                                fmt_reg[`UL_FMT_FORCE]); // R2 R3
        tx_tcnt_reg <= 6'd0;
        tx_st_reg   <= TX_START;
      end else if (tick && tx_st_reg != TX_IDLE) begin
        tx_tcnt_reg <= tx_end ? 6'd0 : tx_tcnt_reg + 6'd1;
        if (tx_end) begin
          unique case (tx_st_reg)
            TX_START: begin
              tx_st_reg  <= TX_DATA;
              tx_bit_reg <= 3'd0;
            end
            TX_DATA: begin
              tx_sh_reg  <= tx_sh_reg >> 1;
              tx_bit_reg <= tx_bit_reg + 3'd1;
              if (tx_bit_reg == last) tx_st_reg <= pen ? TX_PAR : TX_STOP; // R1
            end
            TX_PAR:  tx_st_reg <= TX_STOP;
            TX_STOP: tx_st_reg <= TX_IDLE;
            default: tx_st_reg <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  wire         rx_in   = loop ? tx_wire : rxd; // R12
  wire [5:0]   rx_lim  = (rx_st_reg == RX_START) ? `UL_HALF : `UL_OVS;
  wire         rx_samp = tick & (rx_tcnt_reg == rx_lim - 6'd1);
  wire         rx_done = (rx_st_reg == RX_STOP) & rx_samp;
  wire [7:0]   rx_al   = rx_sh_reg >> (2'd3 - wl); // R23
  wire         rx_brk  = rx_zero_reg & ~rx_in; // R19
  wire         rx_pe   = pen & (rx_pbit_reg != par_calc(rx_al, wl,
                         fmt_reg[`UL_FMT_PTYP], fmt_reg[`UL_FMT_FORCE])); // R1 R2 R3 R24
  wire [10:0]  rx_ent  = {rx_brk, ~rx_in, rx_pe, rx_al}; // R18
  wire         full    = cnt_reg == `UL_DEPTH;
  wire         push    = rx_done & ~full;
  wire         pop     = rd_pop & (cnt_reg != 7'd0);
  wire [10:0]  head    = mem[rd_ptr_reg];
  wire         push_t  = push & (rx_ent[10:8] != 3'b000);
  wire         pop_t   = pop & (head[10:8] != 3'b000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_reg   <= RX_IDLE;
      rx_tcnt_reg <= 6'd0;
      rx_bit_reg  <= 3'd0;
      rx_sh_reg   <= 8'h00;
      rx_pbit_reg <= 1'b0;
      rx_zero_reg <= 1'b0;
    end else if (ce) begin
      if (rx_st_reg == RX_IDLE) begin
        rx_tcnt_reg <= 6'd0;
        if (!rx_in) rx_st_reg <= RX_START;
      end else if (rx_st_reg == RX_BRKW) begin
        if (rx_in) rx_st_reg <= RX_IDLE; // R19
      end else if (tick) begin
        rx_tcnt_reg <= rx_samp ? 6'd0 : rx_tcnt_reg + 6'd1;
        if (rx_samp) begin
          unique case (rx_st_reg)
            RX_START: begin
              rx_st_reg   <= rx_in ? RX_IDLE : RX_DATA;
              rx_bit_reg  <= 3'd0;
              rx_zero_reg <= 1'b1;
            end
            RX_DATA: begin
              rx_sh_reg   <= {rx_in, rx_sh_reg[7:1]};
              rx_zero_reg <= rx_zero_reg & ~rx_in;
              rx_bit_reg  <= rx_bit_reg + 3'd1;
              if (rx_bit_reg == last) rx_st_reg <= pen ? RX_PAR : RX_STOP; // R1
            end
            RX_PAR: begin
              rx_pbit_reg <= rx_in;
              rx_zero_reg <= rx_zero_reg & ~rx_in;
              rx_st_reg   <= RX_STOP;
            end
            default: rx_st_reg <= rx_brk ? RX_BRKW : RX_IDLE; // R19
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Receive FIFO with error tags
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (ce && push) mem[wr_ptr_reg] <= rx_ent;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg  <= 6'd0;
      rd_ptr_reg  <= 6'd0;
      cnt_reg     <= 7'd0;
      err_cnt_reg <= 7'd0;
      ovr_reg     <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 6'd1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 6'd1;
      cnt_reg     <= cnt_reg + {6'd0, push} - {6'd0, pop}; // R15
      err_cnt_reg <= err_cnt_reg + {6'd0, push_t} - {6'd0, pop_t}; // R22
      ovr_reg     <= (rx_done & full) | (ovr_reg & ~rd_lcs); // R16
    end
  end

  // ----------------------------------------
  // Status words
  // ----------------------------------------
  wire         empty_rx = cnt_reg == 7'd0;
  wire [7:0]   line_condition_status = {err_cnt_reg != 7'd0, // R22
                      ~thr_full_reg & (tx_st_reg == TX_IDLE), // R21
                      ~thr_full_reg, // R20
                      head[10:8] & {3{~empty_rx}}, // R17 R18 R19
                      ovr_reg, ~empty_rx}; // R15 R16
  wire [3:0]   msr_st = loop ? {moc_reg[`UL_MOC_OP2], moc_reg[`UL_MOC_OP1],
                                moc_reg[`UL_MOC_DTR], moc_reg[`UL_MOC_RTS]}
                             : ~{cd_n, ri_n, dsr_n, cts_n}; // R8 R12
  wire [3:0]   dset  = {msr_st[3] ^ msr_prev_reg[3], msr_prev_reg[2] & ~msr_st[2],
                        msr_st[1] ^ msr_prev_reg[1], msr_st[0] ^ msr_prev_reg[0]};
  wire [7:0]   rd_byte =
      (ar_idx == `UL_IDX_DATA) ? (dlab ? div_reg[7:0] : head[7:0]) : // R5
      (ar_idx == `UL_IDX_DIVH) ? (dlab ? div_reg[15:8] : 8'h00) :
      (ar_idx == `UL_IDX_DIVF) ? (dlab ? divf_reg : 8'h00) :
      (ar_idx == `UL_IDX_FMT)  ? fmt_reg :
      (ar_idx == `UL_IDX_MOC)  ? moc_reg :
      (ar_idx == `UL_IDX_LCS)  ? line_condition_status :
      (ar_idx == `UL_IDX_MIS)  ? (bank ? tcr_reg : {msr_st, delta_reg}) : // R9
      (ar_idx == `UL_IDX_SPR)  ? (bank ? tlr_reg : spr_reg) : // R10
      (ar_idx == `UL_IDX_EFR)  ? efr_reg :
      (ar_idx == `UL_IDX_FCTL) ? fctl_reg : 8'h00;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_reg      <= `UL_FMT_RST;
      moc_reg      <= 8'h00;
      spr_reg      <= `UL_SPR_RST;
      tcr_reg      <= 8'h00;
      tlr_reg      <= 8'h00;
      efr_reg      <= 8'h00;
      fctl_reg     <= 8'h00;
      div_reg      <= `UL_DIV_RST;
      divf_reg     <= 8'h00;
      thr_reg      <= 8'h00;
      thr_full_reg <= 1'b0;
      msr_prev_reg <= 4'h0;
      delta_reg    <= 4'h0;
    end else if (ce) begin
      if (we_fmt) fmt_reg <= w_data_reg;
      if (we_moc) moc_reg <= moc_wr;
      if (we_spr) spr_reg <= w_data_reg;
      if (we_tcr) tcr_reg <= w_data_reg;
      if (we_tlr) tlr_reg <= w_data_reg;
      if (we_efr) efr_reg <= w_data_reg;
      if (we_divl) div_reg[7:0] <= w_data_reg;
      if (we_divh) div_reg[15:8] <= w_data_reg;
      if (we_divf) divf_reg <= w_data_reg;
      if (we_fctl) fctl_reg <= w_data_reg;
      else if (moc_reg[`UL_MOC_XANY] && rx_done) fctl_reg[`UL_FCTL_HALT] <= 1'b0; // R13
      if (we_data) thr_reg <= w_data_reg;
      thr_full_reg <= we_data | (thr_full_reg & ~tx_load); // R20
      msr_prev_reg <= msr_st;
      delta_reg    <= dset | (delta_reg & ~{4{rd_msr}});
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_idx_reg    <= 4'h0;
      w_data_reg    <= 8'h00;
      w_strb_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UL_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UL_RESP_OK;
    end else if (ce) begin
      aw_have_reg   <= aw_nx;
      w_have_reg    <= w_nx;
      s_axi_awready <= ~aw_nx & ~bv_nx;
      s_axi_wready  <= ~w_nx & ~bv_nx;
      s_axi_bvalid  <= bv_nx;
      s_axi_arready <= ~rv_nx;
      s_axi_rvalid  <= rv_nx;
      if (aw_hs) aw_idx_reg <= s_axi_awaddr[5:2];
      if (w_hs) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_do) s_axi_bresp <= (aw_idx_reg > `UL_IDX_FCTL) ? `UL_RESP_ERR : `UL_RESP_OK;
      if (rd_do) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= ar_bad ? `UL_RESP_ERR : `UL_RESP_OK;
      end
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd      <= 1'b1;
      dtr_n    <= 1'b1;
      rts_n    <= 1'b1;
      op2_n    <= 1'b1;
      irq      <= 1'b0;
      irq_oe_n <= 1'b1;
    end else if (ce) begin
      txd      <= loop | tx_wire; // R4 R12
      dtr_n    <= loop | ~moc_reg[`UL_MOC_DTR]; // R6
      rts_n    <= loop | ~moc_reg[`UL_MOC_RTS]; // R7
      op2_n    <= ~moc_reg[`UL_MOC_OP2]; // R11
      irq      <= ~empty_rx;
      irq_oe_n <= ~moc_reg[`UL_MOC_OP2]; // R11
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_break_line_low: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    ce && fmt_reg[`UL_FMT_BRK] && !loop |=> !txd)
    else $error("break not holding line low");
  chk_dtr_pin_level: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    ce && !loop |=> dtr_n == !$past(moc_reg[`UL_MOC_DTR]))
    else $error("terminal ready pin wrong");
  chk_op2_int_pair: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    ce |=> irq_oe_n == op2_n && op2_n == !$past(moc_reg[`UL_MOC_OP2]))
    else $error("output two and interrupt enable disagree");
  chk_overrun_drop: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    ce && rx_done && full |=> ovr_reg && cnt_reg == $past(cnt_reg) - {6'd0, $past(pop)})
    else $error("overrun not flagged or byte stored");
  chk_fifo_err_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R22
    ce && push_t |=> line_condition_status[7])
    else $error("tagged byte did not raise fifo error");
  chk_idle_flag_busy: assert property (@(posedge aclk) disable iff (!aresetn) // R21
    tx_st_reg != TX_IDLE || thr_full_reg |-> !line_condition_status[6])
    else $error("idle flag set while busy");
  chk_thre_on_load: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    ce && we_data |=> !line_condition_status[5] ##1 1'b1)
    else $error("holding empty not cleared on load");
  chk_ready_on_push: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    ce && push && !pop |=> line_condition_status[0] && cnt_reg != 7'd0)
    else $error("data ready not set after push");
endmodule

/* testbench/uart_line_modem_status_control_bench.sv */
// Self-checking bench of the format, modem and status block
`timescale 1ns/1ps
module uart_line_modem_status_control_bench;
  logic        aclk, aresetn, ce, rxd, cts_n, dsr_n, ri_n, cd_n;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, got;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        txd, dtr_n, rts_n, op2_n, irq, irq_oe_n;
  logic [11:0] frm;
  logic [7:0]  f, d;
  int          bad_count, total_checks, n, p, v;
  int          exp_q[$];
  ulmsc_top u_ulmsc_top (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awaddr, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
    .s_axi_bready, .s_axi_arvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rready, .rxd, .cts_n, .dsr_n, .ri_n, .cd_n, .txd, .dtr_n, .rts_n,
    .op2_n, .irq, .irq_oe_n);
  ulmsc_remote u_ulmsc_remote (.aclk(aclk), .line_in(txd), .line_out(rxd));
  // ----------------------------------------
  // Model and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int par(input int x, input logic [7:0] c);
    if (c[5]) return c[4] ? 0 : 1;
    return c[4] ? $countones(x) % 2 : 1 - $countones(x) % 2;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 200) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] x);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(k);
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic rc(input logic [3:0] i, input logic [31:0] e);
    int k;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    got = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(k);
    chk(got, e);
  endtask
  // ----------------------------------------
  // Clock, reset and scenarios
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ce, cts_n, dsr_n, ri_n, cd_n} = 5'h1f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {12'h0, 32'h0, 4'hf};
    seed = 32'hd5fe;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(4'h3, 32'h05);
    rc(4'h4, 32'h00);
    rc(4'h7, 32'hff);
    rc(4'h5, 32'h60);
    rc(4'hc, 32'h00);
    chk({30'h0, rsp}, 32'h2);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      wr(4'h4, k[7:0]);
      @(negedge aclk);
      chk({dtr_n, rts_n, op2_n, irq_oe_n}, {~k[0], ~k[1], ~k[3], ~k[3]});
    end
    wr(4'h4, 8'h00);
    $display("test modem outputs done");
    wr(4'h7, 8'h5a);
    wr(4'h8, 8'h10);
    wr(4'h4, 8'h04);
    wr(4'h7, 8'h33);
    wr(4'h6, 8'h77);
    rc(4'h7, 32'h33);
    rc(4'h6, 32'h77);
    wr(4'h4, 8'h00);
    rc(4'h7, 32'h5a);
    rc(4'h6, 32'h00);
    wr(4'h8, 8'h00);
    wr(4'h3, 8'h83);
    rc(4'h0, 32'h01);
    $display("test banked registers done");
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      f = {2'b00, m[1:0], 2'b10, m[1:0]};
      n = 5 + m;
      wr(4'h3, f);
      fork
        u_ulmsc_remote.grab(n + 2, frm);
        begin
          wr(4'h0, d);
          rc(4'h5, 32'h20);
        end
      join
      v = int'(d) & ((1 << n) - 1);
      chk({20'h0, frm}, v | (par(v, f) << n) | (1 << (n + 1)));
      chk({31'h0, u_ulmsc_remote.lost}, 32'h0);
    end
    repeat (24) @(posedge aclk);
    rc(4'h5, 32'h60);
    $display("test transmit formats done");
    for (int k = 0; k < 8; k++) begin
      f = {2'b00, k[1:0], 4'b1011};
      wr(4'h3, f);
      seed = lfsr(seed);
      p = par(int'(seed[7:0]), f) ^ (k / 4);
      u_ulmsc_remote.send(seed[7:0], 8, p, 1'b1);
      exp_q.push_back(int'(seed[7:0]));
      rc(4'h5, (k > 3) ? 32'he5 : 32'h61);
      rc(4'h0, exp_q.pop_front());
    end
    rc(4'h5, 32'h60);
    $display("test receive parity done");
    wr(4'h3, 8'h43);
    repeat (40) @(posedge aclk);
    chk({31'h0, txd}, 32'h0);
    wr(4'h3, 8'h03);
    repeat (4) @(posedge aclk);
    chk({31'h0, txd}, 32'h1);
    u_ulmsc_remote.send(8'h00, 8, -1, 1'b0);
    rc(4'h5, 32'hf9);
    rc(4'h0, 32'h00);
    rc(4'h5, 32'h60);
    $display("test break done");
    wr(4'h4, 8'h17);
    rc(4'h6, 32'h73);
    wr(4'h0, 8'ha5);
    repeat (200) @(posedge aclk);
    chk({29'h0, txd, dtr_n, rts_n}, 32'h7);
    rc(4'h5, 32'h61);
    rc(4'h0, 32'ha5);
    $display("test loopback done");
    wr(4'h8, 8'h10);
    wr(4'h4, 8'h20);
    wr(4'h9, 8'h01);
    wr(4'h0, 8'h3c);
    rc(4'h5, 32'h00);
    u_ulmsc_remote.send(8'h96, 8, -1, 1'b1);
    rc(4'h9, 32'h00);
    rc(4'h5, 32'h21);
    rc(4'h0, 32'h96);
    $display("test resume done");
    for (int k = 0; k < 65; k++) begin
      u_ulmsc_remote.send(k[7:0], 8, -1, 1'b1);
      if (k < 64) exp_q.push_back(k);
    end
    rc(4'h5, 32'h63);
    rc(4'h5, 32'h61);
    while (exp_q.size() > 0) rc(4'h0, exp_q.pop_front());
    rc(4'h5, 32'h60);
    $display("test overrun done");
    wr(4'h4, 8'hc0);
    rc(4'h4, 32'h80);
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h21);
    rc(4'h4, 32'h81);
    $display("test prescaler done");
    end_sim();
  end
endmodule

/* testbench/ulmsc_remote.sv */
// Remote serial device on the far end of the line
`timescale 1ns/1ps
module ulmsc_remote (
  input  wire logic aclk,
  input  wire logic line_in,
  output logic      line_out
);
  logic lost;
  initial begin
    line_out = 1'b1;
    lost = 1'b0;
  end
  // One bit time, sixteen clocks at divisor one
  task automatic put(input logic b);
    line_out <= b;
    repeat (16) @(posedge aclk);
  endtask
  // Start, data LSB first, optional parity, stop, idle
  task automatic send(input logic [7:0] d, input int n, input int p, input logic s);
    @(posedge aclk);
    put(1'b0);
    for (int k = 0; k < n; k++) put(d[k]);
    if (p >= 0) put(p[0]);
    put(s);
    line_out <= 1'b1;
    repeat (32) @(posedge aclk);
  endtask
  // Mid-bit samples of n bits after a start bit
  task automatic grab(input int n, output logic [11:0] v);
    int w;
    v = '0;
    for (w = 0; w < 3000 && line_in !== 1'b0; w++) @(posedge aclk);
    lost = (w == 3000);
    repeat (8) @(posedge aclk);
    for (int k = 0; k < n; k++) begin
      repeat (16) @(posedge aclk);
      v[k] = line_in;
    end
  endtask
endmodule
